// file: hdl/mtec_defines.svh
// Register offsets, field positions, reload values and codes of the timer.
// Assumes inclusion by bare name from design files.
`ifndef MTEC_DEFINES_SVH
`define MTEC_DEFINES_SVH

`define MTEC_OFF_CTRL 8'h00
`define MTEC_OFF_CNT 8'h04
`define MTEC_OFF_RELOAD 8'h08
`define MTEC_OFF_STATUS 8'h0C
`define MTEC_OFF_MASK 8'h10
`define MTEC_OFF_OUT 8'h14

`define MTEC_CTRL_START 0
`define MTEC_CTRL_MODE_LO 1
`define MTEC_CTRL_MODE_HI 3
`define MTEC_CTRL_UP 4
`define MTEC_CTRL_FREE 5
`define MTEC_CTRL_MSEL 6
`define MTEC_CTRL_OS_TRIG 7

`define MTEC_ST_IRQ 0
`define MTEC_ST_RELOAD 1

`define MTEC_RESP_OKAY 2'h0
`define MTEC_RESP_SLVERR 2'h2
`define MTEC_ALL_ONES 16'hFFFF
`define MTEC_ALL_ZERO 16'h0000
`define MTEC_UNDEF_LOAD 16'hDEAD

`endif

// file: hdl/mtec_pkg.sv
// Types shared by the timer design files.
// Assumes the defines header is compiled alongside.
`default_nettype none
package mtec_pkg;
  typedef enum logic [2:0] {
    MTEC_TIMER = 3'h0,
    MTEC_EVENT = 3'h1,
    MTEC_ONESHOT = 3'h2,
    MTEC_PWM = 3'h3,
    MTEC_MEASURE = 3'h4
  } mtec_mode_t;
endpackage
`default_nettype wire

// file: hdl/mtec_edge_sync.sv
// Edge detector for the timer input pin, with a two-stage synchroniser.
// Assumes one clock; edge pulse is one cycle long.
`default_nettype none
module mtec_edge_sync (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic pin_in, // Raw input pin
  input wire logic falling, // Select falling edge
  output logic edge_pulse // One-cycle pulse on selected edge
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign edge_pulse = falling ? (s3 & ~s2) : (s2 & ~s3);
endmodule
`default_nettype wire

// file: hdl/mtec_timer.sv
// Multimode 16-bit timer with AXI4-Lite register slave and interrupt.
// Assumes one 50 MHz clock, async active-high reset, synchronous pins.
`default_nettype none
`include "mtec_defines.svh"

// Function
// - Selecting PWM from reset/timer/event sets flag
// - Stop in PWM: high drops low, sets flag
// - Timer read at reload returns all ones
// - Written counter value readable before start
// - Event read at reload: ones underflow, zeros overflow
// - One-shot stop: reload, output low, set flag
// - Selecting one-shot from reset/timer/event sets flag
// - Measure select change while counting sets flag
// - First measured edge loads undefined, no flag
module mtec_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic timer_x_io_pin_in, // Event or measured input pin
  output logic timer_x_io_pin_out, // Pin output level
  output logic timer_x_io_pin_oe, // Pin output enable
  output logic timer_a_pulse_output, // Pulse output
  output logic irq // Level interrupt
);
  logic [7:0] ctrl;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] reload;
  logic [WIDTH-1:0] pwm_high;
  logic [1:0] status;
  logic [1:0] mask;
  logic pulse;
  logic after_reset;
  logic first_edge;
  logic reload_ones;
  logic reload_zeros;
  logic ev_pulse;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic have_aw;
  logic have_w;
  logic wr_go;
  logic [WIDTH-1:0] meas_cnt;
  logic set_irq;
  logic set_rel;

  mtec_pkg::mtec_mode_t mode;
  mtec_pkg::mtec_mode_t next_mode;
  logic start;
  logic next_start;
  logic up;
  logic free_run;
  logic msel;
  logic next_msel;

  function automatic logic is_plain(input mtec_pkg::mtec_mode_t m);
    is_plain = (m == mtec_pkg::MTEC_TIMER) || (m == mtec_pkg::MTEC_EVENT);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  mtec_edge_sync u_edge (
    .clk(clk),
    .rst(rst),
    .pin_in(timer_x_io_pin_in),
    .falling(ctrl[`MTEC_CTRL_UP]),
    .edge_pulse(ev_pulse)
  );

  assign mode = mtec_pkg::mtec_mode_t'(
    ctrl[`MTEC_CTRL_MODE_HI:`MTEC_CTRL_MODE_LO]);
  assign start = ctrl[`MTEC_CTRL_START];
  assign up = ctrl[`MTEC_CTRL_UP];
  assign free_run = ctrl[`MTEC_CTRL_FREE];
  assign msel = ctrl[`MTEC_CTRL_MSEL];
  assign wr_go = have_aw && have_w && !s_axi_bvalid;
  assign next_mode = mtec_pkg::mtec_mode_t'(
    wr_data[`MTEC_CTRL_MODE_HI:`MTEC_CTRL_MODE_LO]);
  assign next_start = wr_data[`MTEC_CTRL_START];
  assign next_msel = wr_data[`MTEC_CTRL_MSEL];

  // Write channel capture: address and data in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else if (wr_go) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w <= 1'b1;
        wr_data <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MTEC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (hit(wr_addr, `MTEC_OFF_CTRL) || hit(wr_addr, `MTEC_OFF_CNT) ||
          hit(wr_addr, `MTEC_OFF_RELOAD) ||
          hit(wr_addr, `MTEC_OFF_STATUS) ||
          hit(wr_addr, `MTEC_OFF_MASK) || hit(wr_addr, `MTEC_OFF_OUT)) begin
        s_axi_bresp <= `MTEC_RESP_OKAY;
      end else begin
        s_axi_bresp <= `MTEC_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control and mask registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= 8'h00;
      mask <= 2'h0;
      pwm_high <= '0;
      after_reset <= 1'b1;
    end else begin
      if (wr_go && hit(wr_addr, `MTEC_OFF_CTRL) && s_axi_wstrb[0]) begin
        ctrl <= wr_data[7:0];
        after_reset <= 1'b0;
      end
      if (wr_go && hit(wr_addr, `MTEC_OFF_MASK) && s_axi_wstrb[0]) begin
        mask <= wr_data[1:0];
      end
      if (wr_go && hit(wr_addr, `MTEC_OFF_OUT)) begin
        pwm_high <= wr_data[WIDTH-1:0];
      end
    end
  end

  // Counter, reload register and reload markers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      reload <= '0;
      reload_ones <= 1'b0;
      reload_zeros <= 1'b0;
      first_edge <= 1'b0;
      meas_cnt <= '0;
    end else begin
      reload_ones <= 1'b0;
      reload_zeros <= 1'b0;
      if (wr_go && hit(wr_addr, `MTEC_OFF_RELOAD)) begin
        reload <= wr_data[WIDTH-1:0];
      end
      if (wr_go && hit(wr_addr, `MTEC_OFF_CNT) && !start) begin
        count <= wr_data[WIDTH-1:0];
        if (mode != mtec_pkg::MTEC_MEASURE) begin
          reload <= wr_data[WIDTH-1:0];
        end
      end else if (wr_go && hit(wr_addr, `MTEC_OFF_CTRL) && start &&
                   !next_start && (mode == mtec_pkg::MTEC_ONESHOT)) begin
        count <= reload;
      end else if (start) begin
        unique case (mode)
          mtec_pkg::MTEC_TIMER, mtec_pkg::MTEC_ONESHOT,
          mtec_pkg::MTEC_PWM: begin
            if (count == '0) begin
              count <= reload;
              reload_ones <= 1'b1;
            end else begin
              count <= count - 1'b1;
            end
          end
          mtec_pkg::MTEC_EVENT: begin
            if (ev_pulse) begin
              if (!up && count == '0) begin
                count <= free_run ? `MTEC_ALL_ONES : reload;
                reload_ones <= 1'b1;
              end else if (up && count == `MTEC_ALL_ONES) begin
                count <= free_run ? `MTEC_ALL_ZERO : reload;
                reload_zeros <= 1'b1;
              end else begin
                count <= up ? count + 1'b1 : count - 1'b1;
              end
            end
          end
          mtec_pkg::MTEC_MEASURE: begin
            meas_cnt <= meas_cnt + 1'b1;
            if (ev_pulse) begin
              meas_cnt <= '0;
              first_edge <= 1'b0;
              reload <= first_edge ? `MTEC_UNDEF_LOAD : meas_cnt;
            end
          end
          default: begin
            count <= count;
          end
        endcase
      end
      if (wr_go && hit(wr_addr, `MTEC_OFF_CTRL) && next_start && !start) begin
        first_edge <= 1'b1;
        meas_cnt <= '0;
      end
    end
  end

  // Output pin level for one-shot and PWM
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse <= 1'b0;
      timer_a_pulse_output <= 1'b0;
      timer_x_io_pin_out <= 1'b0;
      timer_x_io_pin_oe <= 1'b0;
    end else begin
      if (wr_go && hit(wr_addr, `MTEC_OFF_CTRL) && start && !next_start) begin
        pulse <= 1'b0;
      end else if (start && mode == mtec_pkg::MTEC_PWM) begin
        pulse <= (count > pwm_high) ? 1'b0 : 1'b1;
      end else if (start && mode == mtec_pkg::MTEC_ONESHOT) begin
        pulse <= (count != '0);
      end else if (!start) begin
        pulse <= pulse;
      end
      timer_a_pulse_output <= pulse;
      timer_x_io_pin_out <= pulse;
      timer_x_io_pin_oe <= (mode == mtec_pkg::MTEC_PWM) ||
                           (mode == mtec_pkg::MTEC_ONESHOT);
    end
  end

  always_comb begin
    set_irq = 1'b0;
    set_rel = reload_ones | reload_zeros;
    if (wr_go && hit(wr_addr, `MTEC_OFF_CTRL)) begin
      if ((next_mode == mtec_pkg::MTEC_PWM ||
           next_mode == mtec_pkg::MTEC_ONESHOT) &&
          (after_reset || is_plain(mode))) begin
        set_irq = 1'b1;
      end
      if (start && !next_start && mode == mtec_pkg::MTEC_PWM && pulse) begin
        set_irq = 1'b1;
      end
      if (start && !next_start && mode == mtec_pkg::MTEC_ONESHOT) begin
        set_irq = 1'b1;
      end
      if (start && mode == mtec_pkg::MTEC_MEASURE &&
          next_msel != msel) begin
        set_irq = 1'b1;
      end
    end
    if (start && (mode == mtec_pkg::MTEC_MEASURE) && ev_pulse &&
        !first_edge) begin
      set_irq = 1'b1;
    end
    if (start && mode == mtec_pkg::MTEC_ONESHOT && count == '0 &&
        pulse) begin
      set_irq = 1'b1;
    end
    if (start && (mode == mtec_pkg::MTEC_TIMER) && count == '0) begin
      set_irq = 1'b1;
    end
  end

  // Interrupt request flag: set wins over a software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= 2'h0;
    end else begin
      if (wr_go && hit(wr_addr, `MTEC_OFF_STATUS) && s_axi_wstrb[0]) begin
        if (wr_data[`MTEC_ST_IRQ]) begin
          status[`MTEC_ST_IRQ] <= 1'b0;
        end
        if (wr_data[`MTEC_ST_RELOAD]) begin
          status[`MTEC_ST_RELOAD] <= 1'b0;
        end
      end
      if (set_irq) begin
        status[`MTEC_ST_IRQ] <= 1'b1;
      end
      if (set_rel) begin
        status[`MTEC_ST_RELOAD] <= 1'b1;
      end
    end
  end

  // Interrupt output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // Read channel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MTEC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `MTEC_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      unique case (s_axi_araddr)
        `MTEC_OFF_CTRL: s_axi_rdata[7:0] <= ctrl;
        `MTEC_OFF_CNT: begin
          if (reload_ones) begin
            s_axi_rdata[15:0] <= `MTEC_ALL_ONES;
          end else if (reload_zeros) begin
            s_axi_rdata[15:0] <= `MTEC_ALL_ZERO;
          end else begin
            s_axi_rdata[WIDTH-1:0] <= count;
          end
        end
        `MTEC_OFF_RELOAD: s_axi_rdata[WIDTH-1:0] <= reload;
        `MTEC_OFF_STATUS: s_axi_rdata[1:0] <= status;
        `MTEC_OFF_MASK: s_axi_rdata[1:0] <= mask;
        `MTEC_OFF_OUT: s_axi_rdata[WIDTH-1:0] <= pwm_high;
        default: s_axi_rresp <= `MTEC_RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: dv/mtec_pulse_src.sv
// Pulse source on the timer input pin.
// Assumes the bench raises go for one clock.
`default_nettype none
module mtec_pulse_src (
  input wire logic clk, // Clock
  input wire logic [3:0] n, // Pulses per burst
  input wire logic go, // Starts a burst
  output logic pin, // Timer input level
  output logic busy // Burst running
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] left = 5'h00;
  logic [1:0] ph = 2'h0;
  assign busy = left != 5'h00;
  initial pin = 1'b0;
  // Four clocks per level so the synchroniser sees each one
  always @(posedge clk) begin
    if (go && !busy) begin
      left <= {n, 1'b0};
      ph <= 2'h0;
    end else if (busy) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        pin <= ~pin;
        left <= left - 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/mtec_timer_monitor.sv
// Checker on the timer ports: bus answers and pin levels.
// Assumes one clock and the async active-high reset.
`default_nettype none
module mtec_timer_monitor (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] s_axi_awaddr, // Aw addr
  input wire logic s_axi_awvalid, // Aw valid
  input wire logic s_axi_awready, // Aw ready
  input wire logic [31:0] s_axi_wdata, // W data
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic [1:0] s_axi_bresp, // B resp
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic [7:0] s_axi_araddr, // Ar addr
  input wire logic s_axi_arvalid, // Ar valid
  input wire logic s_axi_arready, // Ar ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic [1:0] s_axi_rresp, // R resp
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic timer_x_io_pin_out, // Pin level
  input wire logic timer_a_pulse_output, // Pulse out
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] wa, ra;
  logic [31:0] wd;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wa <= 8'h00;
      ra <= 8'h00;
      wd <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
      if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
    end
  end
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("awready stayed high");
  chk_rd_resp: assert property (s_axi_rvalid |->
    (ra inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14} ?
    s_axi_rresp == 2'h0 : s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0))
    else $error("bad read response");
  chk_ctrl_upper: assert property (s_axi_rvalid && ra == 8'h00 |->
    s_axi_rdata[31:8] == 24'h000000) else $error("ctrl upper bits set");
  chk_out_mirror: assert property (
    timer_a_pulse_output == timer_x_io_pin_out) else $error("outputs split");
  chk_stop_low: assert property (
    $rose(s_axi_bvalid) && wa == 8'h00 && !wd[0] &&
    wd[3:1] inside {3'h2, 3'h3} |-> ##[0:3] !timer_x_io_pin_out)
    else $error("output high after stop");
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property ($fell(timer_x_io_pin_out));
endmodule
bind mtec_timer mtec_timer_monitor mon_u (.*);
`default_nettype wire

// file: dv/tb_top.sv
// Bench for the timer: register tasks, mode and pin scenarios.
// Assumes the pulse source model and the bound checker.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 4'hF, np = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, go = 1'b0, pbusy;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, timer_x_io_pin_in, timer_x_io_pin_out;
  logic timer_x_io_pin_oe, timer_a_pulse_output, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [2:0] pm[5] = '{3'h0, 3'h1, 3'h0, 3'h1, 3'h3};
  logic [2:0] nm[5] = '{3'h3, 3'h3, 3'h2, 3'h2, 3'h2};
  logic fe[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  int errors = 0, tests_run = 0;
  always #10 clk = ~clk;
  mtec_timer dut_u (.*);
  mtec_pulse_src src_u (.clk(clk), .n(np), .go(go),
    .pin(timer_x_io_pin_in), .busy(pbusy));
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    tb = 1'b0;
    for (k = 0; k < 50 && !tb; k++) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    if (!tb) chk("bvalid", 32'h1, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    tr = 1'b0;
    for (k = 0; k < 50 && !tr; k++) begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      q = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    if (!tr) chk("rvalid", 32'h1, 32'h0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
    rd(a);
    chk($sformatf("reg %h", a), e, q & m);
  endtask
  task automatic pk(input string nm, input logic e, ref logic s);
    @(negedge clk);
    chk(nm, {31'h0, e}, {31'h0, s});
    @(posedge clk);
  endtask
  task automatic pulses(input logic [3:0] n);
    int k;
    np <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    for (k = 0; k < 200 && pbusy !== 1'b0; k++) @(negedge clk);
    @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h4);
    pk("irq", 1'b1, irq);
    rdc(8'h0C, 32'h1, 32'h1);
    wr(8'h0C, 32'h1);
    pk("irq", 1'b0, irq);
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, {28'h0, pm[i], 1'b0});
      wr(8'h0C, 32'h1);
      wr(8'h00, {28'h0, nm[i], 1'b0});
      rdc(8'h0C, 32'h1, {31'h0, fe[i]});
      wr(8'h0C, 32'h1);
    end
    $display("test mode_flags done");
    wr(8'h04, 32'h0100);
    rdc(8'h04, 32'hFFFF, 32'h0100);
    wr(8'h00, 32'h85);
    repeat (20) @(posedge clk);
    pk("pin", 1'b1, timer_x_io_pin_out);
    pk("oe", 1'b1, timer_x_io_pin_oe);
    wr(8'h00, 32'h04);
    pk("pin", 1'b0, timer_x_io_pin_out);
    rdc(8'h04, 32'hFFFF, 32'h0100);
    rdc(8'h0C, 32'h1, 32'h1);
    $display("test oneshot_stop done");
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, 32'h6);
      wr(8'h14, i ? 32'h0 : 32'hFFFF);
      wr(8'h04, 32'h4000);
      wr(8'h0C, 32'h1);
      wr(8'h00, 32'h7);
      repeat (10) @(posedge clk);
      pk("pin", !i, timer_x_io_pin_out);
      pk("pulse", !i, timer_a_pulse_output);
      wr(8'h00, 32'h6);
      pk("pin", 1'b0, timer_x_io_pin_out);
      rdc(8'h0C, 32'h1, {31'h0, !i});
    end
    $display("test pwm_stop done");
    wr(8'h00, 32'h8);
    wr(8'h0C, 32'h1);
    wr(8'h00, 32'h9);
    pulses(4'h1);
    rdc(8'h08, 32'hFFFF, 32'hDEAD);
    rdc(8'h0C, 32'h1, 32'h0);
    pk("oe", 1'b0, timer_x_io_pin_oe);
    wr(8'h00, 32'h49);
    rdc(8'h0C, 32'h1, 32'h1);
    $display("test measure done");
    wr(8'h00, 32'h32);
    wr(8'h04, 32'hFFFE);
    wr(8'h00, 32'h33);
    pulses(4'h3);
    rdc(8'h04, 32'hFFFF, 32'h0001);
    wr(8'h00, 32'h32);
    wr(8'h04, 32'h0005);
    rdc(8'h04, 32'hFFFF, 32'h0005);
    $display("test event_wrap done");
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h1);
    rdc(8'h04, 32'hFFFF, 32'hFFFF);
    wr(8'h00, 32'h0);
    $display("test timer_reload done");
    wr(8'h20, 32'h1);
    chk("bresp", 32'h2, {30'h0, rs});
    rd(8'h20);
    chk("rresp", 32'h2, {30'h0, rs});
    chk("rdata", 32'h0, q);
    $display("test unmapped done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
